// file: shared/zqc_map.vh
// Constants for the ZQ calibration sequencer inside the memory device
// Functional notes
// - First long calibration during power-up runs a full driver and termination calibration.
// - On completion, calibrated codes are transferred to the I/O drivers and termination.
// - First long calibration after reset is given the initial calibration window.
// - Every later long calibration is given the operational window.
// - Short calibration finishes calibration and transfer within the short window.
// - One short calibration corrects at least a fixed step within 64 clocks.
// - ZQ current path switched off once calibration is achieved.
// - No self-started recalibration after self-refresh exit.
`ifndef ZQC_MAP_VH
`define ZQC_MAP_VH
// Window lengths in clock cycles
`define ZQC_INIT_CYC 512
`define ZQC_OPER_CYC 256
`define ZQC_SHORT_CYC 64
// Impedance code width and mid-scale reset value
`define ZQC_CODE_W 6
`define ZQC_CODE_RST 6'h20
// Code step applied per compare during a short calibration
`define ZQC_SHORT_STEP 6'h01
`endif

// file: design/zqc_engine.v
// ZQ calibration engine and code transfer of the memory device
`timescale 1ns/1ns
`default_nettype none
`include "zqc_map.vh"
module zqc_engine #(
  parameter INIT_CYC = `ZQC_INIT_CYC,
  parameter OPER_CYC = `ZQC_OPER_CYC,
  parameter SHORT_CYC = `ZQC_SHORT_CYC,
  parameter CW = `ZQC_CODE_W
) (
  input wire clk, // 10 MHz device clock
  input wire rst_n, // Async reset, active low
  input wire cmd_zqcl, // Registered long calibration command
  input wire cmd_zqcs, // Registered short calibration command
  input wire cmp_ron_hi, // Driver comparator: impedance above reference
  input wire cmp_rtt_hi, // Termination comparator: value above reference
  output reg busy_q, // Calibration window in progress
  output reg init_done_q, // First long calibration completed
  output reg zq_cur_en_q, // ZQ current path enable
  output reg [CW-1:0] driver_output_impedance_q, // Code at I/O driver
  output reg [CW-1:0] termination_resistance_q, // Code at termination
  output reg update_q // One-cycle pulse when codes move to I/O
);
  // A window is counted from the edge that takes the command.
  // The engine searches in its own registers; the I/O codes only
  // change on the last cycle, so drivers never see a half-done search.
  // Commands arriving inside a window are dropped without a trace,
  // so the controller must keep the channel quiet until busy falls.

  // Sequencer states, binary coded
  localparam ST_IDLE = 2'd0;
  localparam ST_INIT = 2'd1;
  localparam ST_OPER = 2'd2;
  localparam ST_SHORT = 2'd3;
  // Counter loads, one less than each window length
  localparam integer INIT_M1 = INIT_CYC - 1;
  localparam integer OPER_M1 = OPER_CYC - 1;
  localparam integer SHORT_M1 = SHORT_CYC - 1;
  localparam [9:0] INIT_LD = INIT_M1[9:0];
  localparam [9:0] OPER_LD = OPER_M1[9:0];
  localparam [9:0] SHORT_LD = SHORT_M1[9:0];

  // Sequencer state and window counter
  reg [1:0] st_q;
  reg [1:0] st_d;
  reg [9:0] cnt_q;
  reg [9:0] cnt_d;
  // Marks that a long calibration was taken since reset
  reg first_seen_q;
  reg first_seen_d;
  // Engine codes, kept apart from the codes at the I/O
  reg [CW-1:0] ron_eng_q;
  reg [CW-1:0] ron_eng_d;
  reg [CW-1:0] rtt_eng_q;
  reg [CW-1:0] rtt_eng_d;
  // Next values of the outputs
  reg busy_d;
  reg init_done_d;
  reg zq_cur_en_d;
  reg [CW-1:0] driver_output_impedance_d;
  reg [CW-1:0] termination_resistance_d;
  reg update_d;
  // Decoded window conditions
  wire take_long;
  wire take_short;
  wire in_win;
  wire last_cyc;
  wire step_en;

  // Step a code toward the reference, saturating at either end
  function [CW-1:0] step;
    input [CW-1:0] code;
    input hi;
    begin
      if (hi && code != {CW{1'b1}}) begin
        step = code + `ZQC_SHORT_STEP;
      end else if (!hi && code != {CW{1'b0}}) begin
        step = code - `ZQC_SHORT_STEP;
      end else begin
        step = code;
      end
    end
  endfunction

  // Counter load for a taken command
  function [9:0] win_load;
    input lng;
    input seen;
    begin
      if (!lng) begin
        win_load = SHORT_LD;
      end else if (seen) begin
        win_load = OPER_LD;
      end else begin
        win_load = INIT_LD;
      end
    end
  endfunction

  // Long windows step every cycle; short ones every sixteenth
  function pace;
    input [1:0] st;
    input [9:0] cnt;
    begin
      case (st)
        ST_INIT: pace = 1'b1;
        ST_OPER: pace = 1'b1;
        ST_SHORT: pace = (cnt[3:0] == 4'h0);
        default: pace = 1'b0;
      endcase
    end
  endfunction

  // Commands are taken only from idle; long wins over short
  assign take_long = (st_q == ST_IDLE) && cmd_zqcl;
  assign take_short = (st_q == ST_IDLE) && !cmd_zqcl && cmd_zqcs;
  assign in_win = (st_q != ST_IDLE);
  assign last_cyc = in_win && (cnt_q == 10'h000);
  assign step_en = pace(st_q, cnt_q);

  // Next state and window count
  always @* begin
    st_d = st_q;
    cnt_d = cnt_q;
    first_seen_d = first_seen_q;
    case (st_q)
      ST_IDLE: begin
        if (take_long) begin
          st_d = first_seen_q ? ST_OPER : ST_INIT;
          cnt_d = win_load(1'b1, first_seen_q);
          first_seen_d = 1'b1;
        end else if (take_short) begin
          st_d = ST_SHORT;
          cnt_d = win_load(1'b0, first_seen_q);
        end
      end
      default: begin
        if (last_cyc) begin
          st_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - 10'h001;
        end
      end
    endcase
  end

  // Engine search toward the comparator reference
  always @* begin
    ron_eng_d = ron_eng_q;
    rtt_eng_d = rtt_eng_q;
    if (step_en) begin
      ron_eng_d = step(ron_eng_q, cmp_ron_hi);
      rtt_eng_d = step(rtt_eng_q, cmp_rtt_hi);
    end
  end

  // Status and transfer of the final engine codes to the I/O
  always @* begin
    busy_d = busy_q;
    zq_cur_en_d = zq_cur_en_q;
    init_done_d = init_done_q;
    update_d = 1'b0;
    driver_output_impedance_d = driver_output_impedance_q;
    termination_resistance_d = termination_resistance_q;
    if (take_long || take_short) begin
      busy_d = 1'b1;
      zq_cur_en_d = 1'b1;
    end
    if (last_cyc) begin
      // Includes the step made on this last cycle
      driver_output_impedance_d = ron_eng_d;
      termination_resistance_d = rtt_eng_d;
      update_d = 1'b1;
      busy_d = 1'b0;
      zq_cur_en_d = 1'b0;
      if (st_q == ST_INIT) begin
        init_done_d = 1'b1;
      end
    end
  end

  // Sequencer registers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      cnt_q <= 10'h000;
      first_seen_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      first_seen_q <= first_seen_d;
    end
  end

  // Engine registers, mid-scale after reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ron_eng_q <= `ZQC_CODE_RST;
      rtt_eng_q <= `ZQC_CODE_RST;
    end else begin
      ron_eng_q <= ron_eng_d;
      rtt_eng_q <= rtt_eng_d;
    end
  end

  // Output registers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      init_done_q <= 1'b0;
      zq_cur_en_q <= 1'b0;
      update_q <= 1'b0;
      driver_output_impedance_q <= `ZQC_CODE_RST;
      termination_resistance_q <= `ZQC_CODE_RST;
    end else begin
      busy_q <= busy_d;
      init_done_q <= init_done_d;
      zq_cur_en_q <= zq_cur_en_d;
      update_q <= update_d;
      driver_output_impedance_q <= driver_output_impedance_d;
      termination_resistance_q <= termination_resistance_d;
    end
  end
endmodule
`default_nettype wire

// file: tb/zqc_chk.sv
// Port assertions for the calibration sequencer
`timescale 1ns/1ns
`default_nettype none
module zqc_chk (
  input wire logic clk, // Device clock
  input wire logic rst_n, // Async reset, active low
  input wire logic cmd_zqcl, // Long command
  input wire logic cmd_zqcs, // Short command
  input wire logic busy_q, // Window in progress
  input wire logic init_done_q, // First long done
  input wire logic zq_cur_en_q, // ZQ current path
  input wire logic update_q // Transfer pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_end; !busy_q && update_q; endsequence
  a_init_win: assert property (cmd_zqcl && !busy_q && !init_done_q
    |=> busy_q[*8] ##8 busy_q ##1 s_end) else $error("init window");
  a_oper_win: assert property (cmd_zqcl && !busy_q && init_done_q
    |=> busy_q[*8] ##1 s_end) else $error("oper window");
  a_short_win: assert property (cmd_zqcs && !cmd_zqcl && !busy_q
    |=> busy_q[*4] ##1 s_end) else $error("short window");
  a_update_fall: assert property (update_q == $fell(busy_q)) else $error("upd");
  a_cur_busy: assert property (zq_cur_en_q == busy_q) else $error("cur");
  a_no_self: assert property (!busy_q && !cmd_zqcl && !cmd_zqcs |=> !busy_q)
    else $error("idle");
  a_flag_set: assert property ($rose(init_done_q) |-> s_end) else $error("flag");
  a_flag_keep: assert property (init_done_q |=> init_done_q) else $error("lost");
endmodule
bind zqc_engine zqc_chk u_zqc_chk (.clk(clk), .rst_n(rst_n), .cmd_zqcl(cmd_zqcl),
  .cmd_zqcs(cmd_zqcs), .busy_q(busy_q), .init_done_q(init_done_q),
  .zq_cur_en_q(zq_cur_en_q), .update_q(update_q));
`default_nettype wire

// file: tb/zqc_ctl.sv
// Controller model registering requests into calibration commands
`timescale 1ns/1ns
`default_nettype none
module zqc_ctl (
  input wire logic clk, // Device clock
  input wire logic rl, // Long request, only from precharged idle
  input wire logic rs, // Short request, CKE high and ODT off
  input wire logic rude, // Misuse: keep requesting while busy
  input wire logic busy_q, // Window in progress, DQ left released
  output var logic cl = 1'b0, // Long command
  output var logic cs = 1'b0 // Short command
);
  // Quiet channel while busy unless misuse is ordered
  always @(posedge clk) {cl, cs} <= {rl, rs} & {2{rude | !busy_q}};
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the calibration sequencer
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk = 0, rst_n = 0, rl = 0, rs = 0, rude = 0, hd = 0, ht = 0;
  wire cl, cs, busy, idn, cur, upd;
  wire [5:0] dz, tz;
  logic [5:0] d0, t0;
  int bad_count = 0, check_count = 0, n;
  logic [8:0] rows [4] = '{9'h190, 9'h148, 9'h0c4, 9'h004}; // Long, up, up, cycles
  zqc_engine #(.INIT_CYC(16), .OPER_CYC(8), .SHORT_CYC(4)) u_zqc_engine (.clk(clk),
    .rst_n(rst_n), .cmd_zqcl(cl), .cmd_zqcs(cs), .cmp_ron_hi(hd), .cmp_rtt_hi(ht),
    .busy_q(busy), .init_done_q(idn), .zq_cur_en_q(cur), .driver_output_impedance_q(dz),
    .termination_resistance_q(tz), .update_q(upd));
  zqc_ctl u_zqc_ctl (.clk(clk), .rl(rl), .rs(rs), .rude(rude), .busy_q(busy), .cl(cl), .cs(cs));
  always #50 clk = ~clk;
  task automatic chk(logic [5:0] exp, logic [5:0] got, string what);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One request, then count busy cycles until the window closes
  task automatic run(logic lng, logic d, logic t);
    n = 0;
    @(posedge clk) {rl, rs, hd, ht} <= {lng, !lng, d, t};
    @(posedge clk) {rl, rs} <= {1'b0, rude};
    for (int i = 0; !(n > 0 && busy === 1'b0); i++) begin
      @(negedge clk) n += (busy === 1'b1);
      if (i > 60) begin bad_count++; finish_test(); end
    end
    chk(1, upd, "update");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1;
    @(negedge clk) chk(6'h20, dz, "reset code");
    chk(6'h20, tz, "reset term code");
    foreach (rows[k]) begin
      d0 = dz;
      t0 = tz;
      run(rows[k][8], rows[k][7], rows[k][6]);
      chk(rows[k][5:0], 6'(n), "window");
      chk(0, cur, "current");
      chk(rows[k][7:6], {dz > d0, tz > t0}, "codes");
      chk(1, idn, "flag");
      $display("row %0d done", k);
    end
    @(posedge clk) rude <= 1;
    run(1, 0, 0);
    chk(8, 6'(n), "refused");
    @(posedge clk) {rude, rs} <= 2'b00;
    repeat (8) @(negedge clk);
    @(posedge clk) rl <= 1;
    @(posedge clk) rl <= 0;
    repeat (4) @(posedge clk);
    rst_n <= 0;
    @(negedge clk) chk(6'h00, {idn, busy, dz[3:0]}, "mid reset");
    @(posedge clk) rst_n <= 1;
    run(1, 1, 1);
    chk(16, 6'(n), "init again");
    $display("awkward cases done");
    finish_test();
  end
endmodule
`default_nettype wire
